// *** logic/tsq_pkg.sv ***
// Constants shared by the trigger sequencer clock and timing configuration
//
// Overview of operation
// (RULE1) Top three bits select clock; 110/111 reserved
// (RULE2) Source clock divided by prescaler value plus one
// (RULE3) Trigger pulse lasts width field plus one
// (RULE4) Width field zero gives one-cycle pulse
// (RULE5) Watchdog code 111 times out after 512
// (RULE6) Codes 110 and 101 give 256, 128
// (RULE7) Watchdog code 001 times out after 8
// (RULE8) Watchdog code 000 disables the watchdog
// (RULE9) Step restarts watchdog; timeout sets clearable flag
// (RULE10) Fields reset to zero; bit 3 reads zero
package tsq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;

    ////////////////////////////////////////////////////////////////////////
    // Control register layout
    localparam int SRC_LSB = 13;
    localparam int SRC_W = 3;
    localparam int DIV_LSB = 8;
    localparam int DIV_W = 5;
    localparam int PWD_LSB = 4;
    localparam int PWD_W = 4;
    localparam int WDS_LSB = 0;
    localparam int WDS_W = 3;
    localparam int CTRL_W = 16;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // Bit 3 is unimplemented and never stored
    localparam logic [15:0] CTRL_WMASK = 16'hFFF7;

    ////////////////////////////////////////////////////////////////////////
    // Status register layout
    localparam int STS_ERR_BIT = 0;
    localparam int STS_TRIG_BIT = 1;
    localparam int STS_PEND_BIT = 2;

    ////////////////////////////////////////////////////////////////////////
    // Clock source codes
    localparam int NUM_SRC = 6;
    localparam logic [2:0] SRC_RSVD_LO = 3'h6;

    ////////////////////////////////////////////////////////////////////////
    // Watchdog codes and counts
    localparam logic [2:0] WDS_OFF = 3'h0;
    localparam int WD_CNT_W = 10;
    localparam logic [9:0] WD_BASE = 10'h008;

    // Timeout length in sequencer clocks for a watchdog select code
    function automatic logic [9:0] wd_limit(input logic [2:0] code);
        logic [9:0] lim;
        lim = 10'h000;
        if (code != WDS_OFF)
        begin
            lim = WD_BASE << (code - 3'h1);
        end
        return lim;
    endfunction : wd_limit

endpackage : tsq_pkg

// *** logic/tsq_wd_if.sv ***
// Interface between the configuration top and the sequencer watchdog
interface tsq_wd_if;
    logic seq_tick;       // One pulse per divided sequencer clock
    logic step_adv;       // Sequencer moved to a new step
    logic [2:0] sel;      // Watchdog select field
    logic timeout;        // One-cycle timeout pulse

    modport ctrl (output seq_tick, output step_adv, output sel,
                  input timeout);
    modport wdog (input seq_tick, input step_adv, input sel,
                  output timeout);
endinterface : tsq_wd_if

// *** logic/tsq_wdog.sv ***
// Sequencer watchdog counting divided sequencer clocks
module tsq_wdog
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link to the configuration top
    tsq_wd_if.wdog wd
);

    ////////////////////////////////////////////////////////////////////////
    // Counter state
    logic [tsq_pkg::WD_CNT_W-1:0] cnt_reg;   // Sequencer clocks so far
    logic timeout_reg;                       // Registered timeout pulse
    logic [tsq_pkg::WD_CNT_W-1:0] limit;     // Active timeout length

    assign limit = tsq_pkg::wd_limit(wd.sel); // [RULE5] [RULE6] [RULE7]
    assign wd.timeout = timeout_reg;

    ////////////////////////////////////////////////////////////////////////
    // Count sequencer clocks; a step or a disabled select restarts at zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= '0;
        end
        else if (wd.step_adv || wd.sel == tsq_pkg::WDS_OFF)
        begin
            // Step advance wins over a tick in the same cycle
            cnt_reg <= '0; // [RULE9] [RULE8]
        end
        else if (wd.seq_tick)
        begin
            if (cnt_reg + 10'h001 >= limit)
            begin
                cnt_reg <= '0;
            end
            else
            begin
                cnt_reg <= cnt_reg + 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timeout pulses one cycle after the tick that completes the count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timeout_reg <= 1'b0;
        end
        else
        begin
            timeout_reg <= wd.seq_tick && !wd.step_adv &&
                           wd.sel != tsq_pkg::WDS_OFF &&
                           (cnt_reg + 10'h001 >= limit); // [RULE5] [RULE8]
        end
    end

endmodule : tsq_wdog

// *** logic/tsq_top.sv ***
// Trigger sequencer clock, pulse width and watchdog configuration top
module tsq_top
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Candidate source clock enables, same pclk domain
    input wire logic [5:0] src_tick,
    // Sequencer side
    input wire logic step_adv,
    input wire logic trig_req,
    output logic seq_tick,
    output logic trig_out,
    output logic wdt_timeout,
    output logic wdt_error
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [15:0] ctrl_reg;                  // Control register
    logic err_reg;                          // Sticky watchdog error
    logic [31:0] prdata_reg;                // Registered read data
    logic [4:0] div_cnt_reg;                // Prescaler count
    logic seq_tick_reg;                     // Divided clock pulse
    logic trig_reg;                         // Trigger output level
    logic pend_reg;                         // Trigger waiting for a tick
    logic [3:0] pw_cnt_reg;                 // Remaining pulse ticks
    logic [2:0] src_sel;                    // Clock source field
    logic [4:0] div_val;                    // Prescaler field
    logic [3:0] pwd_val;                    // Pulse width field
    logic [2:0] wds_val;                    // Watchdog select field
    logic src_hit;                          // Selected source ticked
    logic setup_ph;                         // APB setup cycle
    logic wr_ctrl;                          // Write to control register
    logic wr_sts;                           // Write to status register
    logic mapped;                           // Address is decoded

    tsq_wd_if wd_if ();

    ////////////////////////////////////////////////////////////////////////
    // Field extraction
    assign src_sel = ctrl_reg[tsq_pkg::SRC_LSB +: tsq_pkg::SRC_W];
    assign div_val = ctrl_reg[tsq_pkg::DIV_LSB +: tsq_pkg::DIV_W];
    assign pwd_val = ctrl_reg[tsq_pkg::PWD_LSB +: tsq_pkg::PWD_W];
    assign wds_val = ctrl_reg[tsq_pkg::WDS_LSB +: tsq_pkg::WDS_W];

    ////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states, so pready is always high
    assign setup_ph = psel && !penable;
    assign mapped = (paddr == tsq_pkg::ADDR_CTRL) ||
                    (paddr == tsq_pkg::ADDR_STATUS);
    assign wr_ctrl = psel && penable && pwrite &&
                     paddr == tsq_pkg::ADDR_CTRL;
    assign wr_sts = psel && penable && pwrite &&
                    paddr == tsq_pkg::ADDR_STATUS;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Control register with byte strobes; bit 3 never stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= tsq_pkg::CTRL_RESET; // [RULE10]
        end
        else if (wr_ctrl)
        begin
            if (pstrb[0])
            begin
                ctrl_reg[7:0] <= pwdata[7:0] &
                                 tsq_pkg::CTRL_WMASK[7:0]; // [RULE10]
            end
            if (pstrb[1])
            begin
                // Reserved source codes are stored as written;
                // software must avoid them
                ctrl_reg[15:8] <= pwdata[15:8] &
                                  tsq_pkg::CTRL_WMASK[15:8]; // [RULE1]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky error flag, write one to clear; a new timeout wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            err_reg <= 1'b0;
        end
        else if (wd_if.timeout)
        begin
            err_reg <= 1'b1; // [RULE9]
        end
        else if (wr_sts && pstrb[0] && pwdata[tsq_pkg::STS_ERR_BIT])
        begin
            err_reg <= 1'b0; // [RULE9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data captured in the setup cycle, presented in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0000_0000;
        end
        else if (setup_ph && !pwrite)
        begin
            prdata_reg <= 32'h0000_0000;
            if (paddr == tsq_pkg::ADDR_CTRL)
            begin
                // Bit 3 is masked so it always reads zero
                prdata_reg[15:0] <= ctrl_reg &
                                    tsq_pkg::CTRL_WMASK; // [RULE10]
            end
            else if (paddr == tsq_pkg::ADDR_STATUS)
            begin
                prdata_reg[tsq_pkg::STS_ERR_BIT] <= err_reg;
                prdata_reg[tsq_pkg::STS_TRIG_BIT] <= trig_reg;
                prdata_reg[tsq_pkg::STS_PEND_BIT] <= pend_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection; reserved codes pick no source at all, which
    // freezes the sequencer clock rather than running on a guess
    always_comb
    begin
        src_hit = 1'b0;
        if (src_sel < tsq_pkg::SRC_RSVD_LO)
        begin
            src_hit = src_tick[src_sel]; // [RULE1]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: one output pulse every div_val+1 source ticks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_reg <= 5'h00;
            seq_tick_reg <= 1'b0;
        end
        else
        begin
            seq_tick_reg <= 1'b0;
            if (src_hit)
            begin
                if (div_cnt_reg >= div_val)
                begin
                    div_cnt_reg <= 5'h00;
                    seq_tick_reg <= 1'b1; // [RULE2]
                end
                else
                begin
                    div_cnt_reg <= div_cnt_reg + 5'h01; // [RULE2]
                end
            end
        end
    end

    assign seq_tick = seq_tick_reg;

    ////////////////////////////////////////////////////////////////////////
    // Trigger pulse: a request waits for the next sequencer tick so the
    // pulse spans whole sequencer cycles, then holds pwd_val+1 of them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_reg <= 1'b0;
            trig_reg <= 1'b0;
            pw_cnt_reg <= 4'h0;
        end
        else
        begin
            if (seq_tick_reg && (pend_reg || trig_req))
            begin
                // Restart: a new request retriggers a running pulse
                pend_reg <= 1'b0;
                trig_reg <= 1'b1;
                pw_cnt_reg <= pwd_val; // [RULE3]
            end
            else
            begin
                if (trig_req)
                begin
                    pend_reg <= 1'b1;
                end
                if (seq_tick_reg && trig_reg)
                begin
                    if (pw_cnt_reg == 4'h0)
                    begin
                        trig_reg <= 1'b0; // [RULE4]
                    end
                    else
                    begin
                        pw_cnt_reg <= pw_cnt_reg - 4'h1; // [RULE3]
                    end
                end
            end
        end
    end

    assign trig_out = trig_reg;

    ////////////////////////////////////////////////////////////////////////
    // Watchdog hookup
    assign wd_if.seq_tick = seq_tick_reg;
    assign wd_if.step_adv = step_adv; // [RULE9]
    assign wd_if.sel = wds_val;
    assign wdt_timeout = wd_if.timeout;
    assign wdt_error = err_reg;

    tsq_wdog u_wdog
    (
        .pclk(pclk),
        .presetn(presetn),
        .wd(wd_if.wdog)
    );

endmodule : tsq_top

// *** verif/tsq_top_monitor.sv ***
// Port checker for the trigger sequencer configuration top
module tsq_top_monitor
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave side
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    // Sequencer side
    input wire logic [5:0] src_tick,
    input wire logic step_adv,
    input wire logic seq_tick,
    input wire logic trig_out,
    input wire logic wdt_timeout,
    input wire logic wdt_error
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////
    // One domain, so one clock and one reset
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_tick_cause: assert property (seq_tick |-> $past(|src_tick))
        else $error("divided tick without a source tick");
    a_trig_rise: assert property
        ($rose(trig_out) |-> $past(seq_tick))
        else $error("trigger rose off a divided tick");
    a_trig_fall: assert property
        ($fell(trig_out) |-> $past(seq_tick))
        else $error("trigger fell off a divided tick");
    // Shortest interval is 8 ticks, at most one tick a cycle
    a_timeout_gap: assert property
        (wdt_timeout |=> !wdt_timeout[*7])
        else $error("timeouts closer than 8 cycles");
    a_timeout_cause: assert property
        (wdt_timeout |-> $past(seq_tick && !step_adv))
        else $error("timeout without a counted tick");
    a_step_restart: assert property (step_adv |=> !wdt_timeout[*8])
        else $error("timeout too soon after a step");
    a_err_rise: assert property
        ($rose(wdt_error) |-> wdt_timeout || $past(wdt_timeout))
        else $error("error flag set without timeout");
    a_err_clear: assert property ($fell(wdt_error) |->
        $past(psel && penable && pwrite && paddr == tsq_pkg::ADDR_STATUS))
        else $error("error flag cleared without a write");
    a_bit3_zero: assert property
        (psel && penable && !pwrite |-> !prdata[3])
        else $error("read data bit 3 not zero");
endmodule : tsq_top_monitor

bind tsq_top tsq_top_monitor u_tsq_top_monitor (.pclk, .presetn, .paddr,
    .psel, .penable, .pwrite, .prdata, .src_tick, .step_adv, .seq_tick,
    .trig_out, .wdt_timeout, .wdt_error);

// *** verif/tsq_top_bench.sv ***
// Self-checking bench for the trigger sequencer configuration top
module tsq_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // Stimulus, observed outputs and tallies
    logic pclk, presetn, psel, penable, pwrite, step_adv, trig_req, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [5:0] src_tick;
    logic pready, pslverr, seq_tick, trig_out, wdt_timeout, wdt_error;
    int fail_count = 0;
    int compares = 0;
    int seed = 32'h5394;
    int n, k;

    tsq_top u_tsq_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .src_tick, .step_adv,
        .trig_req, .seq_tick, .trig_out, .wdt_timeout, .wdt_error);

    ////////////////////////////////////////////////
    // 125 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Fresh random source enables each cycle, so gaps are irregular
    always @(posedge pclk) src_tick <= 6'($random(seed));

    // Control word from field values
    function automatic logic [31:0] ctl(int s, int dv, int pw, int wd);
        return 32'((s << 13) | (dv << 8) | (pw << 4) | wd);
    endfunction : ctl

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic wrap_up;
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    // One APB transfer; holds the request until pready is seen
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // pready is tied high, so this wait ends at once
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Tick spacing; first interval skipped as the prescaler was mid-count
    task automatic div_chk(int s, int dv);
        apb(1'b1, tsq_pkg::ADDR_CTRL, ctl(s, dv, 0, 0));
        repeat (2) @(posedge pclk);
        k = 0;
        for (int t = 0; t < 3000 && k < 4; t++)
        begin
            @(posedge pclk);
            if (seq_tick === 1'b1)
            begin
                if (k > 0)
                    check("src ticks", 32'(dv + 1), 32'(n));
                k++;
                n = 0;
            end
            if (s < 6 && src_tick[s] === 1'b1) n++;
        end
        check("divided ticks", s < 6 ? 4 : 0, k);
    endtask : div_chk

    // Width counted in divided ticks while the output is high
    task automatic trig_chk(int pw);
        apb(1'b1, tsq_pkg::ADDR_CTRL, ctl(0, 1, pw, 0));
        @(posedge pclk);
        trig_req <= 1'b1;
        @(posedge pclk);
        trig_req <= 1'b0;
        n = 0;
        for (int t = 0; t < 400 && trig_out !== 1'b1; t++) @(posedge pclk);
        for (int t = 0; t < 2000 && trig_out === 1'b1; t++)
        begin
            if (seq_tick === 1'b1) n++;
            @(posedge pclk);
        end
        check("pulse periods", 32'(pw + 1), 32'(n));
    endtask : trig_chk

    // Ticks from a step restart to the timeout pulse
    task automatic wd_chk(int c);
        apb(1'b1, tsq_pkg::ADDR_CTRL, ctl(0, 0, 0, c));
        @(posedge pclk);
        step_adv <= 1'b1;
        @(posedge pclk);
        step_adv <= 1'b0;
        n = 0;
        k = 0;
        for (int t = 0; t < 4000 && k == 0; t++)
        begin
            @(posedge pclk);
            if (wdt_timeout === 1'b1)
                k = 1;
            else if (seq_tick === 1'b1)
                n++;
        end
        check("timeout seen", 32'(c != 0), 32'(k));
        if (c != 0)
            check("wd ticks", 32'(8 << (c - 1)), 32'(n));
    endtask : wd_chk

    ////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, step_adv, trig_req} = '0;
        paddr = '0;
        pwdata = '0;
        src_tick = '0;
        pstrb = 4'hF;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, tsq_pkg::ADDR_CTRL, 32'h0);
        check("ctrl reset", 32'h0, rd);
        apb(1'b0, tsq_pkg::ADDR_STATUS, 32'h0);
        check("status reset", 32'h0, rd);
        apb(1'b1, tsq_pkg::ADDR_CTRL, 32'hFFFF);
        apb(1'b0, tsq_pkg::ADDR_CTRL, 32'h0);
        check("ctrl readback", 32'hFFF7, rd);
        // Low byte lane only: the upper byte must keep its value
        pstrb <= 4'h1;
        apb(1'b1, tsq_pkg::ADDR_CTRL, 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, tsq_pkg::ADDR_CTRL, 32'h0);
        check("ctrl lane write", 32'hFF00, rd);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped error", 32'h1, 32'(err));
        for (int s = 0; s < 8; s++)
            div_chk(s, s < 2 ? 31 * s : $random(seed) & 31);
        trig_chk(0);
        trig_chk(15);
        trig_chk($random(seed) & 15);
        for (int c = 0; c < 8; c++)
            wd_chk(c);
        apb(1'b0, tsq_pkg::ADDR_STATUS, 32'h0);
        check("error set", 32'h1, rd & 32'h1);
        check("error pin set", 32'h1, 32'(wdt_error));
        apb(1'b1, tsq_pkg::ADDR_STATUS, 32'h1);
        apb(1'b0, tsq_pkg::ADDR_STATUS, 32'h0);
        check("error cleared", 32'h0, rd & 32'h1);
        check("error pin clear", 32'h0, 32'(wdt_error));
        wrap_up;
    end

    // Hang guard: the sequence needs roughly 13000 cycles
    initial
    begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        wrap_up;
    end
endmodule : tsq_top_bench
